// *** rtl/ingress_timestamp_path.sv ***
// receive timestamp path from host port fifo to time sync unit and dma
`timescale 1ns/1ps
module ingress_timestamp_path #(
  parameter int unsigned EV_DEPTH = ts_path_pkg::EVQ_DEPTH
) (
  input  wire logic                       clk_in,
  input  wire logic                       srst_in,
  input  wire logic                       host_ts_en_in,
  input  wire logic                       event_en_in,
  input  wire logic [ts_path_pkg::ETYPE_W-1:0] etype_cfg_in,
  input  wire logic [ts_path_pkg::TS_W-1:0]    time_now_in,
  input  wire logic                       rx_valid_in,
  input  wire ts_path_pkg::beat_t         rx_beat_in,
  input  wire logic                       rx_preamble_ok_in,
  output logic                            rx_ready_out,
  output logic                            ts_req_out,
  input  wire logic                       ts_ack_in,
  input  wire logic [ts_path_pkg::TS_W-1:0]    ts_value_in,
  output logic                            dma_valid_out,
  output ts_path_pkg::dma_beat_t          dma_beat_out,
  input  wire logic                       dma_ready_in,
  input  wire logic                       ev_pop_in,
  output logic                            ev_valid_out,
  output ts_path_pkg::event_t             ev_data_out,
  output logic                            ev_overflow_out,
  output logic                            locked_out
);
  import ts_path_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_PASS = 2'b10
  } st_t;

  st_t              st_r, st_nxt;
  logic [TS_W-1:0]  ts_r, ts_nxt;
  logic             ts_have_r, ts_have_nxt;
  logic             req_sent_r, req_sent_nxt;
  logic             first_r, first_nxt;
  dma_beat_t        out_r, out_nxt;
  logic             out_v_r, out_v_nxt;
  logic             ev_push;
  event_t           ev_entry;
  logic             take, out_free;

  // =========================================================
  // event capture on matching ethertype
  // ethertype assumed in upper half of the fourth beat is too costly;
  // first beat low half carries it here, a simplification
  always_comb begin
    ev_entry.etype = rx_beat_in.data[ETYPE_W-1:0];
    ev_entry.ts    = time_now_in;
    ev_push = event_en_in && take && rx_beat_in.sop
              && (rx_beat_in.data[ETYPE_W-1:0] == etype_cfg_in);
  end

  event_queue #(
    .DEPTH(EV_DEPTH)
  ) u_evq (
    .clk_in       (clk_in),
    .srst_in      (srst_in),
    .push_in      (ev_push),
    .push_data_in (ev_entry),
    .pop_in       (ev_pop_in),
    .valid_out    (ev_valid_out),
    .data_out     (ev_data_out),
    .full_out     (),
    .overflow_out (ev_overflow_out)
  );

  // =========================================================
  // host port stream with per packet timestamp
  assign out_free = !out_v_r || dma_ready_in;
  assign take     = rx_valid_in && rx_ready_out;

  always_comb begin
    rx_ready_out = 1'b0;
    if (st_r == ST_PASS) begin
      rx_ready_out = out_free;
    end else if (st_r == ST_IDLE) begin
      // without host stamping no wait at all
      rx_ready_out = out_free && !host_ts_en_in;
    end
  end

  always_comb begin
    st_nxt       = st_r;
    ts_nxt       = ts_r;
    ts_have_nxt  = ts_have_r;
    req_sent_nxt = req_sent_r;
    first_nxt    = first_r;
    out_nxt      = out_r;
    out_v_nxt    = out_v_r && !dma_ready_in;
    ts_req_out   = 1'b0;
    unique case (st_r)
      ST_IDLE: begin
        if (rx_valid_in && rx_beat_in.sop && host_ts_en_in) begin
          st_nxt       = ST_WAIT;
          ts_have_nxt  = 1'b0;
          // bad preamble: no request, nothing ever answers
          ts_req_out   = rx_preamble_ok_in;
          req_sent_nxt = rx_preamble_ok_in;
        end else if (take && !rx_beat_in.eop) begin
          st_nxt = ST_PASS;
        end
        first_nxt = 1'b1;
      end
      ST_WAIT: begin
        if (ts_ack_in && req_sent_r) begin
          ts_nxt      = ts_value_in;
          ts_have_nxt = 1'b1;
          st_nxt      = ST_PASS;
        end else if (!host_ts_en_in) begin
          // enable cleared: release packet without a stamp
          st_nxt = ST_PASS;
        end
      end
      ST_PASS: begin
        if (take && rx_beat_in.eop) begin
          st_nxt = ST_IDLE;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
    if (take) begin
      out_nxt.data   = rx_beat_in.data;
      out_nxt.sop    = rx_beat_in.sop;
      out_nxt.eop    = rx_beat_in.eop;
      out_nxt.ts_vld = ts_have_r && first_r && (st_r == ST_PASS);
      out_nxt.ts     = ts_r;
      out_v_nxt      = 1'b1;
      first_nxt      = 1'b0;
      if (st_r == ST_IDLE || rx_beat_in.eop) begin
        ts_have_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      st_r       <= ST_IDLE;
      ts_r       <= '0;
      ts_have_r  <= 1'b0;
      req_sent_r <= 1'b0;
      first_r    <= 1'b1;
      out_r      <= '0;
      out_v_r    <= 1'b0;
    end else begin
      st_r       <= st_nxt;
      ts_r       <= ts_nxt;
      ts_have_r  <= ts_have_nxt;
      req_sent_r <= req_sent_nxt;
      first_r    <= first_nxt;
      out_r      <= out_nxt;
      out_v_r    <= out_v_nxt;
    end
  end

  assign dma_valid_out = out_v_r;
  assign dma_beat_out  = out_r;
  assign locked_out    = (st_r == ST_WAIT) && !req_sent_r;

  // =========================================================
  // checks
  sequence s_sop_held;
    st_r == ST_IDLE && rx_valid_in && rx_beat_in.sop && host_ts_en_in;
  endsequence

  // first beat of a stamped packet leaving towards the host
  sequence s_stamped_take;
    take && st_r == ST_PASS && first_r && ts_have_r;
  endsequence

  a_wait_no_take: assert property (@(posedge clk_in)
    disable iff (srst_in) (st_r == ST_WAIT) |-> !rx_ready_out)
    else $error("beat taken while waiting for timestamp");

  a_sop_enters_wait: assert property (@(posedge clk_in)
    disable iff (srst_in) s_sop_held |=> st_r == ST_WAIT)
    else $error("host mode packet did not wait for stamp");

  a_bad_pre_lock: assert property (@(posedge clk_in)
    disable iff (srst_in)
    s_sop_held ##0 !rx_preamble_ok_in ##1 host_ts_en_in [*3]
    |-> locked_out && st_r == ST_WAIT)
    else $error("corrupt preamble did not lock port");

  a_lock_stays: assert property (@(posedge clk_in)
    disable iff (srst_in) (locked_out && host_ts_en_in) |=> locked_out)
    else $error("lockup cleared while enable still set");

  a_clear_unlocks: assert property (@(posedge clk_in)
    disable iff (srst_in)
    (st_r == ST_WAIT && !host_ts_en_in && !ts_ack_in) |=> st_r == ST_PASS)
    else $error("clearing enable did not release port");

  a_ts_delivered: assert property (@(posedge clk_in)
    disable iff (srst_in) (st_r == ST_WAIT && ts_ack_in && req_sent_r)
    |=> ts_have_r && ts_r == $past(ts_value_in))
    else $error("acknowledged timestamp not held");

  a_first_beat_stamp: assert property (@(posedge clk_in)
    disable iff (srst_in) s_stamped_take |=> dma_valid_out
    && dma_beat_out.ts_vld && dma_beat_out.ts == $past(ts_r))
    else $error("first beat left without its stamp");

  a_later_unstamped: assert property (@(posedge clk_in)
    disable iff (srst_in) (dma_valid_out && !dma_beat_out.sop)
    |-> !dma_beat_out.ts_vld)
    else $error("stamp on a beat other than the first");

  a_req_only_good: assert property (@(posedge clk_in)
    disable iff (srst_in) ts_req_out |-> rx_preamble_ok_in
    && st_r == ST_IDLE && rx_valid_in && rx_beat_in.sop && host_ts_en_in)
    else $error("timestamp request without good sop");

  a_event_push: assert property (@(posedge clk_in)
    disable iff (srst_in) (ev_push && !ev_valid_out) |=> ev_valid_out
    && ev_data_out.ts == $past(time_now_in))
    else $error("matching packet not captured");

  a_disabled_flow: assert property (@(posedge clk_in)
    disable iff (srst_in)
    (!host_ts_en_in && st_r == ST_IDLE && out_free) |-> rx_ready_out)
    else $error("port stalls with host stamping off");
endmodule // ingress_timestamp_path

// *** rtl/ts_path_pkg.sv ***
// shared types and constants for the ingress timestamp path
package ts_path_pkg;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned TS_W        = 64;
  localparam int unsigned ETYPE_W     = 16;
  localparam int unsigned EVQ_DEPTH   = 8;
  localparam logic [ETYPE_W-1:0] ETYPE_DEFAULT = 16'h0A5C;
  localparam logic [7:0] ETYPE_HI_BEAT = 8'h00;

  // one beat of received packet data
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic              sop;
    logic              eop;
  } beat_t;

  // one beat towards the host dma, timestamp rides with the first beat
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic              sop;
    logic              eop;
    logic              ts_vld;
    logic [TS_W-1:0]   ts;
  } dma_beat_t;

  // event fifo entry
  typedef struct packed {
    logic [ETYPE_W-1:0] etype;
    logic [TS_W-1:0]    ts;
  } event_t;
endpackage

// *** rtl/event_queue.sv ***
// flip-flop event queue of captured timestamps
`timescale 1ns/1ps
module event_queue #(
  parameter int unsigned DEPTH = ts_path_pkg::EVQ_DEPTH
) (
  input  wire logic                clk_in,
  input  wire logic                srst_in,
  input  wire logic                push_in,
  input  wire ts_path_pkg::event_t push_data_in,
  input  wire logic                pop_in,
  output logic                     valid_out,
  output ts_path_pkg::event_t      data_out,
  output logic                     full_out,
  output logic                     overflow_out
);
  import ts_path_pkg::*;
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  event_t            mem_r [DEPTH];
  event_t            mem_nxt [DEPTH];
  logic [AW-1:0]     wr_r, wr_nxt, rd_r, rd_nxt;
  logic [AW:0]       cnt_r, cnt_nxt;
  logic              ovf_r, ovf_nxt;
  logic              do_push, do_pop;

  // =========================================================
  // next state
  always_comb begin
    do_pop  = pop_in && (cnt_r != '0);
    do_push = push_in && ((cnt_r != (AW+1)'(DEPTH)) || do_pop);
    mem_nxt = mem_r;
    wr_nxt  = wr_r;
    rd_nxt  = rd_r;
    cnt_nxt = cnt_r;
    ovf_nxt = ovf_r || (push_in && !do_push);
    if (do_push) begin
      mem_nxt[wr_r] = push_data_in;
      wr_nxt = (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
    end
    if (do_pop) begin
      rd_nxt = (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
    end
    cnt_nxt = cnt_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
  end

  // =========================================================
  // registers
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
      ovf_r <= 1'b0;
    end else begin
      wr_r  <= wr_nxt;
      rd_r  <= rd_nxt;
      cnt_r <= cnt_nxt;
      ovf_r <= ovf_nxt;
    end
    mem_r <= mem_nxt;
  end

  assign valid_out    = (cnt_r != '0);
  assign data_out     = mem_r[rd_r];
  assign full_out     = (cnt_r == (AW+1)'(DEPTH));
  assign overflow_out = ovf_r;
endmodule // event_queue

// *** testbench/host_dma_model.sv ***
// host dma and time sync responder model
`timescale 1ns/1ps
module host_dma_model (
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  input  wire logic        slow_in,
  input  wire logic        ts_req_in,
  output logic             ts_ack_out,
  output logic [63:0]      ts_value_out,
  output logic             dma_ready_out
);
  logic [63:0] stamp_r;
  logic [1:0]  ph_r;
  // ==========================================
  // stamp answer one cycle after the request
  always_ff @(posedge clk_in) begin
    ts_ack_out <= !srst_in && ts_req_in;
    stamp_r    <= srst_in ? 64'h1 : stamp_r + 64'(ts_ack_out);
    ph_r       <= srst_in ? 2'h0 : ph_r + 2'h1;
  end
  // value outside the ack cycle changes every cycle, never stale
  assign ts_value_out  = ts_ack_out ? stamp_r : {62'h0, ph_r};
  // slow host stalls three cycles of four
  assign dma_ready_out = !slow_in || ph_r == 2'h3;
endmodule // host_dma_model

// *** testbench/ingress_timestamp_path_bench.sv ***
// self-checking bench for the ingress timestamp path
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_mismatch++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module ingress_timestamp_path_bench;
  import ts_path_pkg::*;
  logic           clk_in = 0, srst_in = 1, host_ts_en = 0, event_en = 0;
  logic           rx_valid = 0, pre_ok = 1, ev_pop = 0, slow = 0;
  logic           rx_ready, ts_req, ts_ack, dma_valid, dma_ready;
  logic           ev_valid, ev_ovf, locked;
  logic [15:0]    etype_cfg = ETYPE_DEFAULT;
  logic [63:0]    time_now = '0, ts_value;
  beat_t          rx_beat = '0;
  dma_beat_t      dma_beat, exp, exp_q[$];
  event_t         ev_data, ev_q[$];
  int             n_mismatch = 0, check_count = 0, cycles = 0;
  int             seed = 74647, host_n = 0;
  ingress_timestamp_path dut (.clk_in, .srst_in, .host_ts_en_in(host_ts_en),
    .event_en_in(event_en), .etype_cfg_in(etype_cfg),
    .time_now_in(time_now), .rx_valid_in(rx_valid), .rx_beat_in(rx_beat),
    .rx_preamble_ok_in(pre_ok), .rx_ready_out(rx_ready),
    .ts_req_out(ts_req), .ts_ack_in(ts_ack), .ts_value_in(ts_value),
    .dma_valid_out(dma_valid), .dma_beat_out(dma_beat),
    .dma_ready_in(dma_ready), .ev_pop_in(ev_pop), .ev_valid_out(ev_valid),
    .ev_data_out(ev_data), .ev_overflow_out(ev_ovf), .locked_out(locked));
  host_dma_model host (.clk_in, .srst_in, .slow_in(slow), .ts_req_in(ts_req),
    .ts_ack_out(ts_ack), .ts_value_out(ts_value),
    .dma_ready_out(dma_ready));
  // ==========================================
  // clock, time base, hang guard
  always #5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    time_now <= time_now + 64'h1;
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      results();
    end
  end
  // ==========================================
  // dma side scoreboard, ts only meaningful on stamped beats
  always @(posedge clk_in) if (dma_valid && dma_ready) begin
    `CHK(exp_q.size() != 0, 1'b1)
    exp = exp_q.pop_front();
    if (!exp.ts_vld) exp.ts = dma_beat.ts;
    `CHK(dma_beat, exp)
  end
  task automatic send(input int n, input logic [15:0] et, input logic ok);
    dma_beat_t e;
    @(posedge clk_in);
    for (int i = 0; i < n; i++) begin
      rx_valid <= 1;
      rx_beat  <= '{data: i ? $random(seed) : {16'h0000, et},
                    sop: i == 0, eop: i == n - 1};
      pre_ok   <= ok;
      @(negedge clk_in);
      `CHK(ts_req, i == 0 && host_ts_en && ok)
      if (i == 0 && host_ts_en && ok) `CHK(rx_ready, 1'b0)
      for (int w = 0; w < 60 && !rx_ready; w++) @(negedge clk_in);
      `CHK(rx_ready, 1'b1)
      e = '{data: rx_beat.data, sop: i == 0, eop: i == n - 1,
            ts_vld: i == 0 && host_ts_en && ok, ts: 64'(host_n + 1)};
      if (e.ts_vld) host_n++;
      exp_q.push_back(e);
      if (i == 0 && event_en && et == etype_cfg && ev_q.size() < EVQ_DEPTH)
        ev_q.push_back('{etype: et, ts: time_now});
      @(posedge clk_in);
    end
    rx_valid <= 0;
  endtask
  task automatic drain();
    event_t e;
    while (ev_q.size() > 0) begin
      @(negedge clk_in);
      e = ev_q.pop_front();
      `CHK(ev_valid, 1'b1)
      `CHK(ev_data, e)
      @(posedge clk_in);
      ev_pop <= 1;
      @(posedge clk_in);
      ev_pop <= 0;
    end
    @(negedge clk_in);
    `CHK(ev_valid, 1'b0)
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_in);
    srst_in <= 0;
    for (int k = 0; k < 4; k++) send(3, 16'h0800, 1);
    $display("test plain stream done");
    host_ts_en <= 1;
    slow       <= 1;
    for (int k = 0; k < 4; k++) send(k + 1, 16'h86DD, 1);
    $display("test host stamps done");
    fork
      send(2, 16'h0800, 0);
      begin
        repeat (8) @(negedge clk_in);
        `CHK(locked, 1'b1)
        `CHK(rx_ready, 1'b0)
        @(posedge clk_in);
        host_ts_en <= 0;
      end
    join
    @(negedge clk_in);
    `CHK(locked, 1'b0)
    $display("test lockup release done");
    event_en <= 1;
    slow     <= 0;
    for (int k = 0; k < 18; k++) send(1, k[0] ? 16'h0800 : etype_cfg, 1);
    @(negedge clk_in);
    `CHK(ev_ovf, 1'b1)
    drain();
    for (int w = 0; w < 200 && exp_q.size() > 0; w++) @(posedge clk_in);
    `CHK(exp_q.size() == 0, 1'b1)
    $display("test event queue done");
    results();
  end
endmodule // ingress_timestamp_path_bench
